/* File: verilog/mmu_debug_monitor.sv */
// MMU breakpoint match, event counters, queue throttle, PA hold and walker
// Assumes the core presents control-space accesses and walk memory answers
`timescale 1ns/1ps
module mmu_debug_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire mmu_debug_pkg::csr_req_t csrReq,
  output logic [31:0] csrRdata,
  input wire logic [mmu_debug_pkg::NUM_TRIG-1:0] trigA,
  input wire logic [mmu_debug_pkg::NUM_TRIG-1:0] trigB,
  input wire logic [mmu_debug_pkg::NUM_TRIG-1:0] trigEnA,
  input wire logic [mmu_debug_pkg::NUM_TRIG-1:0] trigEnB,
  input wire logic [mmu_debug_pkg::NUM_TRIG-1:0] assertCtl,
  input wire logic combineOrA,
  input wire logic combineOrB,
  input wire logic [31:0] matchAddr,
  input wire logic [3:0] matchType,
  input wire logic request_compare_enable,
  input wire logic [3:0] request_type_select,
  output logic breakHit,
  input wire logic lbOpPush,
  input wire logic lbOpPop,
  input wire logic lbOpRequest,
  output logic lbStall,
  input wire logic xlateValid,
  input wire logic xlateIsInstr,
  input wire logic [31:0] xlatePa,
  output logic [31:0] phys_addr_hold,
  output logic [31:0] data_phys_addr_copy,
  output logic [31:0] instr_phys_addr_copy,
  input wire logic walkStart,
  input wire logic walkIsStore,
  input wire logic walkIsIo,
  input wire logic [31:0] walkVa,
  input wire logic [31:0] context_table_base,
  input wire logic [7:0] context_number,
  input wire logic [31:0] tlb_replacement_control,
  input wire logic [4:0] tlb_replacement_counter,
  input wire logic l2PtpHit,
  input wire logic [31:0] l2PtpEntry,
  output mmu_debug_pkg::walk_mem_t walkMem,
  input wire logic walkMemAck,
  input wire logic [31:0] walkMemRdata,
  output logic tlbWrite,
  output logic [4:0] tlbWriteSlot,
  output logic [31:0] tlbWriteEntry,
  output logic walkDone,
  output logic walkFault
);
  import mmu_debug_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers and trigger combine
  logic [31:0] cntA_ff, nxt_cntA;
  logic [31:0] cntB_ff, nxt_cntB;
  logic [10:0] mask_ff, nxt_mask;
  logic [31:0] value_ff, nxt_value;
  logic [1:0] qThr_ff, nxt_qThr;
  logic [2:0] qOcc_ff, nxt_qOcc;
  logic [31:0] rdata_ff, nxt_rdata;
  logic incA, incB;
  logic [NUM_TRIG-1:0] polA, polB;

  assign polA = trigA ^ assertCtl;
  assign polB = trigB ^ assertCtl;
  assign incA = combineOrA ? |(polA & trigEnA) :
                (trigEnA != '0) && ((polA | ~trigEnA) == '1);
  assign incB = combineOrB ? |(polB & trigEnB) :
                (trigEnB != '0) && ((polB | ~trigEnB) == '1);

  // Register next values; writes take priority over counting
  always_comb begin
    logic wr;
    wr = csrReq.req && csrReq.wr;
    nxt_cntA = cntA_ff;
    nxt_cntB = cntB_ff;
    nxt_mask = mask_ff;
    nxt_value = value_ff;
    nxt_qThr = qThr_ff;
    nxt_rdata = rdata_ff;
    if (incA) begin
      nxt_cntA = cntA_ff + 32'h0000_0001;
    end
    if (incB) begin
      nxt_cntB = cntB_ff + 32'h0000_0001;
    end
    if (wr && csrReq.addr == ADDR_CNT_A) begin
      nxt_cntA = csrReq.wdata;
    end else if (wr && csrReq.addr == ADDR_CNT_B) begin
      nxt_cntB = csrReq.wdata;
    end else if (wr && csrReq.addr == ADDR_MASK) begin
      nxt_mask = csrReq.wdata[10:0];
    end else if (wr && csrReq.addr == ADDR_VALUE) begin
      nxt_value = csrReq.wdata;
    end else if (wr && csrReq.addr == ADDR_QTHR_WR) begin
      nxt_qThr = csrReq.wdata[1:0];
    end
    if (csrReq.req && !csrReq.wr) begin
      if (csrReq.addr == ADDR_CNT_A) begin
        nxt_rdata = cntA_ff;
      end else if (csrReq.addr == ADDR_CNT_B) begin
        nxt_rdata = cntB_ff;
      end else if (csrReq.addr == ADDR_MASK) begin
        nxt_rdata = {REV_CODE, 13'h0000, mask_ff};
      end else if (csrReq.addr == ADDR_VALUE) begin
        nxt_rdata = value_ff;
      end else if (csrReq.addr == ADDR_QTHR_RD) begin
        nxt_rdata = {30'h0000_0000, qThr_ff};
      end else if (csrReq.addr == ADDR_QOCC) begin
        nxt_rdata = {29'h0000_0000, qOcc_ff};
      end else begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  // Register state
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cntA_ff <= CNT_RESET;
      cntB_ff <= CNT_RESET;
      mask_ff <= 11'h000;
      value_ff <= 32'h0000_0000;
      qThr_ff <= 2'h0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      cntA_ff <= nxt_cntA;
      cntB_ff <= nxt_cntB;
      mask_ff <= nxt_mask;
      value_ff <= nxt_value;
      qThr_ff <= nxt_qThr;
      rdata_ff <= nxt_rdata;
    end
  end
  assign csrRdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Breakpoint match
  logic [8:0] sliceEq, sliceEn;
  logic upperOk, bit11Ok, lowerOk, typeOk, typeLegal;
  logic hit_ff, nxt_hit;

  assign sliceEn = mask_ff[8:0];
  assign sliceEq[0] = matchAddr[31:24] == value_ff[31:24];
  assign sliceEq[1] = matchAddr[23:18] == value_ff[23:18];
  assign sliceEq[2] = matchAddr[17:12] == value_ff[17:12];
  assign sliceEq[3] = matchAddr[11] == value_ff[11];
  assign sliceEq[4] = matchAddr[10:4] == value_ff[10:4];
  assign sliceEq[5] = matchAddr[3] == value_ff[3];
  assign sliceEq[6] = matchAddr[2] == value_ff[2];
  assign sliceEq[7] = matchAddr[1] == value_ff[1];
  assign sliceEq[8] = matchAddr[0] == value_ff[0];

  assign upperOk = ((sliceEq[2:0] | ~sliceEn[2:0]) == 3'h7)
                   ^ mask_ff[MASK_N_POS];
  assign bit11Ok = (sliceEq[3] | ~sliceEn[3]) ^ mask_ff[MASK_N11_POS];
  assign lowerOk = (sliceEq[8:4] | ~sliceEn[8:4]) == 5'h1F;

  always_comb begin
    case (request_type_select)
      MT_NOP, MT_RD8, MT_RD16, MT_RD32, MT_WR1, MT_WR2, MT_WR4, MT_WR8,
      MT_WR16: typeLegal = 1'b1;
      default: typeLegal = 1'b0;
    endcase
  end
  assign typeOk = !request_compare_enable ||
                  (typeLegal && matchType == request_type_select);

  always_comb begin
    nxt_hit = upperOk && bit11Ok && lowerOk && typeOk;
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= nxt_hit;
    end
  end
  assign breakHit = hit_ff;

  ////////////////////////////////////////////////////////////////////////
  // Local-bus queue occupancy and throttle
  always_comb begin
    nxt_qOcc = qOcc_ff;
    if (lbOpPush && !lbOpPop && qOcc_ff != QUEUE_MAX) begin
      nxt_qOcc = qOcc_ff + 3'h1;
    end else if (lbOpPop && !lbOpPush && qOcc_ff != 3'h0) begin
      nxt_qOcc = qOcc_ff - 3'h1;
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      qOcc_ff <= 3'h0;
    end else begin
      qOcc_ff <= nxt_qOcc;
    end
  end
  // hold core ops while occupancy is above the threshold
  assign lbStall = lbOpRequest && (qOcc_ff > {1'b0, qThr_ff});

  ////////////////////////////////////////////////////////////////////////
  // Physical address holding
  logic [31:0] par_ff, nxt_par, data_phys_addr_copy_ff, nxt_data_phys_addr_copy, instr_phys_addr_copy_ff, nxt_instr_phys_addr_copy;
  always_comb begin
    nxt_par = par_ff;
    nxt_data_phys_addr_copy = data_phys_addr_copy_ff;
    nxt_instr_phys_addr_copy = instr_phys_addr_copy_ff;
    if (xlateValid) begin
      nxt_par = xlatePa;
      if (xlateIsInstr) begin
        nxt_instr_phys_addr_copy = xlatePa;
      end else begin
        nxt_data_phys_addr_copy = xlatePa;
      end
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      par_ff <= 32'h0000_0000;
      data_phys_addr_copy_ff <= 32'h0000_0000;
      instr_phys_addr_copy_ff <= 32'h0000_0000;
    end else begin
      par_ff <= nxt_par;
      data_phys_addr_copy_ff <= nxt_data_phys_addr_copy;
      instr_phys_addr_copy_ff <= nxt_instr_phys_addr_copy;
    end
  end
  assign phys_addr_hold = par_ff;
  assign data_phys_addr_copy = data_phys_addr_copy_ff;
  assign instr_phys_addr_copy = instr_phys_addr_copy_ff;

  ////////////////////////////////////////////////////////////////////////
  // Table walk
  typedef enum logic [2:0] {W_IDLE, W_FETCH, W_WAIT, W_UPDATE, W_UPWAIT,
    W_DONE, W_FAULT} walk_state_t;
  walk_state_t wState_ff, nxt_wState;
  logic [31:0] wAddr_ff, nxt_wAddr;
  logic [1:0] wLevel_ff, nxt_wLevel;
  logic [31:0] wEntry_ff, nxt_wEntry;
  logic wStore_ff, nxt_wStore;
  logic [31:0] beData, idxOff, updEntry;

  assign beData = {walkMemRdata[7:0], walkMemRdata[15:8],
                   walkMemRdata[23:16], walkMemRdata[31:24]};
  always_comb begin
    case (wLevel_ff)
      2'h0: idxOff = {22'h000000, walkVa[31:24], 2'h0};
      2'h1: idxOff = {24'h000000, walkVa[23:18], 2'h0};
      default: idxOff = {24'h000000, walkVa[17:12], 2'h0};
    endcase
  end
  assign updEntry = wEntry_ff | (32'h1 << PTE_REF_POS) |
                    ({31'h0, wStore_ff} << PTE_MOD_POS);

  always_comb begin
    nxt_wState = wState_ff;
    nxt_wAddr = wAddr_ff;
    nxt_wLevel = wLevel_ff;
    nxt_wEntry = wEntry_ff;
    nxt_wStore = wStore_ff;
    case (wState_ff)
      W_IDLE: begin
        // I/O requests never touch the TLB
        if (walkStart && !walkIsIo) begin
          nxt_wStore = walkIsStore;
          nxt_wState = W_FETCH;
          if (tlb_replacement_control[TLB_REPLACEMENT_CONTROL_L2PTP_POS] && l2PtpHit) begin
            nxt_wLevel = 2'h2;
            nxt_wAddr = {l2PtpEntry[31:2], 2'h0};
          end else begin
            nxt_wLevel = 2'h3;
            nxt_wAddr = context_table_base +
                        {22'h000000, context_number, 2'h0};
          end
        end
      end
      W_FETCH: begin
        nxt_wState = W_WAIT;
      end
      W_WAIT: begin
        if (walkMemAck) begin
          nxt_wEntry = beData;
          if (beData[1:0] == ET_PTE && wLevel_ff != 2'h3) begin
            nxt_wAddr = wAddr_ff + idxOff; // Entry address for write-back
            nxt_wState = W_UPDATE;
          end else if (beData[1:0] == ET_PTP &&
                       wLevel_ff != 2'(WALK_LEVELS - 1)) begin
            nxt_wLevel = (wLevel_ff == 2'h3) ? 2'h0 : wLevel_ff + 2'h1;
            nxt_wAddr = {beData[31:2], 2'h0};
            nxt_wState = W_FETCH;
          end else begin
            nxt_wState = W_FAULT;
          end
        end
      end
      W_UPDATE: begin
        nxt_wState = W_UPWAIT;
      end
      W_UPWAIT: begin
        if (walkMemAck) begin
          nxt_wEntry = updEntry;
          nxt_wState = W_DONE;
        end
      end
      W_DONE: nxt_wState = W_IDLE;
      W_FAULT: nxt_wState = W_IDLE;
      default: nxt_wState = W_IDLE;
    endcase
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wState_ff <= W_IDLE;
      wAddr_ff <= 32'h0000_0000;
      wLevel_ff <= 2'h0;
      wEntry_ff <= 32'h0000_0000;
      wStore_ff <= 1'b0;
    end else begin
      wState_ff <= nxt_wState;
      wAddr_ff <= nxt_wAddr;
      wLevel_ff <= nxt_wLevel;
      wEntry_ff <= nxt_wEntry;
      wStore_ff <= nxt_wStore;
    end
  end

  // Walk memory port: index added below root context fetch
  always_comb begin
    walkMem.req = (wState_ff == W_FETCH) || (wState_ff == W_UPDATE);
    walkMem.wr = wState_ff == W_UPDATE;
    walkMem.noCache = 1'b1;
    walkMem.bigEndian = 1'b1;
    walkMem.addr = (wLevel_ff == 2'h3 || wState_ff == W_UPDATE) ?
                   wAddr_ff : wAddr_ff + idxOff;
    walkMem.wdata = {updEntry[7:0], updEntry[15:8], updEntry[23:16],
                     updEntry[31:24]};
  end
  assign tlbWrite = wState_ff == W_DONE;
  assign tlbWriteSlot = tlb_replacement_counter;
  assign tlbWriteEntry = wEntry_ff;
  assign walkDone = wState_ff == W_DONE;
  assign walkFault = wState_ff == W_FAULT;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_CNTA_INC: assert property (@(posedge clock) disable iff (reset)
    incA && !(csrReq.req && csrReq.wr) |=> cntA_ff == $past(cntA_ff) + 1)
    else $error("counter A did not step");
  AST_CNTB_HOLD: assert property (@(posedge clock) disable iff (reset)
    !incB && !(csrReq.req && csrReq.wr) |=> $stable(cntB_ff))
    else $error("counter B moved without trigger");
  AST_QOCC_MAX: assert property (@(posedge clock) disable iff (reset)
    qOcc_ff <= QUEUE_MAX)
    else $error("occupancy above four");
  AST_STALL: assert property (@(posedge clock) disable iff (reset)
    lbOpRequest && qOcc_ff > {1'b0, qThr_ff} |-> lbStall)
    else $error("stall missing over threshold");
  AST_THR_RDPORT: assert property (@(posedge clock) disable iff (reset)
    csrReq.req && csrReq.wr && csrReq.addr == ADDR_QTHR_RD
    |=> $stable(qThr_ff))
    else $error("threshold changed by read port write");
  AST_REV_RO: assert property (@(posedge clock) disable iff (reset)
    csrReq.req && !csrReq.wr && csrReq.addr == ADDR_MASK
    |=> csrRdata[31:24] == REV_CODE)
    else $error("revision field wrong");
  AST_TLB_SLOT: assert property (@(posedge clock) disable iff (reset)
    tlbWrite |-> tlbWriteSlot == tlb_replacement_counter && walkDone)
    else $error("tlb fill slot wrong");
  AST_NO_IO: assert property (@(posedge clock) disable iff (reset)
    wState_ff == W_IDLE && walkStart && walkIsIo |=> wState_ff == W_IDLE)
    else $error("io request started a walk");
  AST_CTX_ADDR: assert property (@(posedge clock) disable iff (reset)
    wState_ff == W_IDLE && walkStart && !walkIsIo &&
    !(tlb_replacement_control[TLB_REPLACEMENT_CONTROL_L2PTP_POS] && l2PtpHit)
    |=> walkMem.req && walkMem.addr ==
        $past(context_table_base) + {22'h0, $past(context_number), 2'h0})
    else $error("context table address wrong");
endmodule

/* File: verilog/mmu_debug_pkg.sv */
// Constants, register map and carrier types for the MMU debug and walk block
// Assumes one core clock; control-space accesses arrive as single-cycle strobes
package mmu_debug_pkg;
  localparam logic [31:0] ADDR_CNT_A = 32'h1000_3010;
  localparam logic [31:0] ADDR_CNT_B = 32'h1000_3014;
  localparam logic [31:0] ADDR_MASK = 32'h1000_3018;
  localparam logic [31:0] ADDR_VALUE = 32'h1000_301C;
  localparam logic [31:0] ADDR_QTHR_WR = 32'h1000_4000;
  localparam logic [31:0] ADDR_QTHR_RD = 32'h1000_6000;
  localparam logic [31:0] ADDR_QOCC = 32'h1000_7000;
  // Mask register field positions
  localparam int MASK_EN_LO = 0;   // Nine slice enables [8:0]
  localparam int MASK_N11_POS = 9;
  localparam int MASK_N_POS = 10;
  localparam int MASK_REV_LO = 24; // Revision code [31:24]
  // Arbitrary revision value, not a real part code
  localparam logic [7:0] REV_CODE = 8'h5A;
  localparam int TLB_REPLACEMENT_CONTROL_L2PTP_POS = 20;
  localparam logic [2:0] QUEUE_MAX = 3'h4;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam int WALK_LEVELS = 3;
  localparam int TLB_ENTRIES = 32;
  // Entry type codes in the low two bits of a table entry
  localparam logic [1:0] ET_INVALID = 2'h0;
  localparam logic [1:0] ET_PTP = 2'h1;
  localparam logic [1:0] ET_PTE = 2'h2;
  localparam int PTE_REF_POS = 5;
  localparam int PTE_MOD_POS = 6;
  localparam int NUM_TRIG = 22;

  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } csr_req_t;

  typedef struct packed {
    logic req;       // One-cycle walk memory access
    logic wr;
    logic noCache;   // Bypass data cache
    logic bigEndian;
    logic [31:0] addr;
    logic [31:0] wdata;
  } walk_mem_t;

  typedef enum logic [3:0] {
    MT_NOP = 4'h0, MT_RD8 = 4'h1, MT_RD16 = 4'h2, MT_RD32 = 4'h4,
    MT_WR1 = 4'h9, MT_WR2 = 4'hA, MT_WR4 = 4'hB, MT_WR8 = 4'hC,
    MT_WR16 = 4'hD
  } mem_type_t;
endpackage

/* File: dv/walk_memory_model.sv */
// Table memory that answers the walker's one-cycle access pulses
// Assumes the walker keeps one access open at a time
`timescale 1ns/1ps
module walk_memory_model (
  input wire logic clock,
  input wire mmu_debug_pkg::walk_mem_t walkMem,
  input wire logic [3:0] ackDelay,
  output logic walkMemAck,
  output logic [31:0] walkMemRdata
);
  import mmu_debug_pkg::*;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] held;
  int readCount;

  function automatic logic [31:0] swap(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  initial begin
    walkMemAck = 1'b0;
    walkMemRdata = 32'h0;
    readCount = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serve one access, answer after the chosen delay, then scramble the bus
  always begin
    @(posedge clock);
    if (walkMem.req === 1'b1) begin
      held = mem.exists(walkMem.addr) ? mem[walkMem.addr] : 32'h0;
      if (walkMem.wr === 1'b1)
        mem[walkMem.addr] = swap(walkMem.wdata);
      else
        readCount++;
      repeat (ackDelay) @(posedge clock);
      #1;
      walkMemAck = 1'b1;
      walkMemRdata = swap(held);
      @(posedge clock);
      #1;
      walkMemAck = 1'b0;
      walkMemRdata = ~walkMemRdata;
    end
  end
endmodule

/* File: dv/mmu_debug_monitor_and_table_walk_tb.sv */
// Self-checking bench for the MMU debug monitor and table walker
// Assumes the package constants and a behavioural table memory
`timescale 1ns/1ps
module mmu_debug_monitor_and_table_walk_tb;
  import mmu_debug_pkg::*;
  logic clock, reset, combineOrA, combineOrB, breakHit, walkMemAck;
  logic [NUM_TRIG-1:0] trigA, trigB, trigEnA, trigEnB, assertCtl;
  logic request_compare_enable, lbOpPush, lbOpPop, lbOpRequest, lbStall;
  logic xlateValid, xlateIsInstr, walkStart, walkIsStore, walkIsIo;
  logic l2PtpHit, tlbWrite, walkDone, walkFault, doneSeen, faultSeen;
  logic [3:0] matchType, request_type_select, ackDelay;
  logic [4:0] tlb_replacement_counter, tlbWriteSlot, slotSeen;
  logic [7:0] context_number;
  logic [31:0] csrRdata, matchAddr, xlatePa, walkVa, context_table_base;
  logic [31:0] tlb_replacement_control, l2PtpEntry, walkMemRdata, rd;
  logic [31:0] phys_addr_hold, data_phys_addr_copy, instr_phys_addr_copy;
  logic [31:0] tlbWriteEntry, entrySeen;
  csr_req_t csrReq;
  walk_mem_t walkMem;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  int reads;
  mem_type_t codes [8] = '{MT_RD8, MT_RD16, MT_RD32, MT_WR1, MT_WR2,
                           MT_WR4, MT_WR8, MT_WR16};

  mmu_debug_monitor mmu_debug_monitor_inst (.*);
  walk_memory_model walk_memory_model_inst (.clock(clock),
    .walkMem(walkMem), .ackDelay(ackDelay), .walkMemAck(walkMemAck),
    .walkMemRdata(walkMemRdata));

  always #12.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic csr_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    #1;
    csrReq = '{req: 1'b1, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    #1;
    csrReq.req = 1'b0;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    @(posedge clock);
    #1;
    csrReq = '{req: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clock);
    #1;
    csrReq.req = 1'b0;
    check(csrRdata, e);
  endtask

  task automatic q_pulse(input logic up, input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      lbOpPush = up;
      lbOpPop = !up;
      @(posedge clock);
      #1;
      lbOpPush = 1'b0;
      lbOpPop = 1'b0;
    end
  endtask

  task automatic bp(input logic [10:0] m, input logic [31:0] a,
                    input logic [3:0] t, input logic e);
    csr_wr(ADDR_MASK, {21'h0, m});
    matchAddr = a;
    matchType = t;
    repeat (2) @(posedge clock);
    #1;
    check({31'h0, breakHit}, {31'h0, e});
  endtask

  task automatic xlate(input logic i, input logic [31:0] pa);
    @(posedge clock);
    #1;
    xlateValid = 1'b1;
    xlateIsInstr = i;
    xlatePa = pa;
    @(posedge clock);
    #1;
    xlateValid = 1'b0;
  endtask

  task automatic walk(input logic [31:0] va, input logic st, input logic l2);
    @(posedge clock);
    #1;
    walkVa = va;
    walkIsStore = st;
    l2PtpHit = l2;
    walkStart = 1'b1;
    reads = walk_memory_model_inst.readCount;
    doneSeen = 1'b0;
    faultSeen = 1'b0;
    @(posedge clock);
    #1;
    walkStart = 1'b0;
    for (int i = 0; i < 300 && !doneSeen && !faultSeen; i++)
      @(posedge clock);
    #1;
    reads = walk_memory_model_inst.readCount - reads;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watch walker pulses and the hang limit
  always @(posedge clock) begin
    cycles++;
    if (tlbWrite === 1'b1) begin
      slotSeen = tlbWriteSlot;
      entrySeen = tlbWriteEntry;
    end
    if (walkDone === 1'b1)
      doneSeen = 1'b1;
    if (walkFault === 1'b1)
      faultSeen = 1'b1;
    if (walkMem.req === 1'b1)
      check({30'h0, walkMem.noCache, walkMem.bigEndian}, 32'h3);
    if (cycles == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    csrReq = '0;
    {trigA, trigB, trigEnA, trigEnB, assertCtl} = '0;
    {combineOrA, combineOrB, request_compare_enable} = '0;
    {lbOpPush, lbOpPop, lbOpRequest, xlateValid, xlateIsInstr} = '0;
    {walkStart, walkIsStore, walkIsIo, l2PtpHit} = '0;
    {matchType, request_type_select, tlb_replacement_counter} = '0;
    {matchAddr, xlatePa, walkVa, tlb_replacement_control, l2PtpEntry} = '0;
    context_table_base = 32'h0000_1000;
    context_number = 8'h02;
    ackDelay = 4'h0;
    repeat (5) @(posedge clock);
    #1;
    reset = 1'b0;
    // Counter A: AND combine, then wrap through all ones
    trigEnA = 22'h3;
    csr_wr(ADDR_CNT_A, 32'hFFFF_FFFE);
    trigA = 22'h1;
    repeat (3) @(posedge clock);
    #1;
    trigA = 22'h3;
    repeat (3) @(posedge clock);
    #1;
    trigA = 22'h0;
    rd_chk(ADDR_CNT_A, 32'h0000_0001);
    // Counter B counts an inverted idle trigger
    csr_wr(ADDR_CNT_B, 32'h0000_0000);
    trigEnB = 22'h2;
    combineOrB = 1'b1;
    assertCtl = 22'h2;
    repeat (4) @(posedge clock);
    #1;
    assertCtl = 22'h0;
    rd_chk(ADDR_CNT_B, 32'h0000_0004);
    // Mask register keeps its revision, compare value reads back
    csr_wr(ADDR_MASK, 32'hFFFF_FFFF);
    rd_chk(ADDR_MASK, {REV_CODE, 24'h0007FF});
    csr_wr(ADDR_VALUE, 32'h1200_0000);
    rd_chk(ADDR_VALUE, 32'h1200_0000);
    // Slice enables and the two invert controls
    bp(11'h001, 32'h12FF_FFFF, 4'h0, 1'b1);
    bp(11'h001, 32'h1300_0000, 4'h0, 1'b0);
    bp(11'h100, 32'hFFFF_FFFE, 4'h0, 1'b1);
    bp(11'h100, 32'h0000_0001, 4'h0, 1'b0);
    bp(11'h401, 32'h12FF_FFFF, 4'h0, 1'b0);
    bp(11'h401, 32'h1300_0000, 4'h0, 1'b1);
    bp(11'h208, 32'h0000_0000, 4'h0, 1'b0);
    bp(11'h208, 32'h0000_0800, 4'h0, 1'b1);
    bp(11'h209, 32'h1200_0800, 4'h0, 1'b1);
    bp(11'h209, 32'h1300_0800, 4'h0, 1'b0);
    // Request type joins the match for every read and write code
    request_compare_enable = 1'b1;
    foreach (codes[i]) begin
      request_type_select = codes[i];
      bp(11'h001, 32'h1200_0000, codes[i], 1'b1);
      bp(11'h001, 32'h1200_0000, ~codes[i], 1'b0);
    end
    // No-op code matches; reserved codes never match
    request_type_select = 4'h0;
    bp(11'h001, 32'h1200_0000, 4'h0, 1'b1);
    request_type_select = 4'h3;
    bp(11'h001, 32'h1200_0000, 4'h3, 1'b0);
    request_type_select = 4'hE;
    bp(11'h001, 32'h1200_0000, 4'hE, 1'b0);
    // Threshold split ports, occupancy and stall
    csr_wr(ADDR_QTHR_WR, 32'h0000_0001);
    rd_chk(ADDR_QTHR_RD, 32'h0000_0001);
    rd_chk(ADDR_QTHR_WR, 32'h0000_0000);
    csr_wr(ADDR_QTHR_RD, 32'h0000_0000);
    rd_chk(ADDR_QTHR_RD, 32'h0000_0001);
    lbOpRequest = 1'b1;
    q_pulse(1'b1, 2);
    check({31'h0, lbStall}, 32'h1);
    rd_chk(ADDR_QOCC, 32'h0000_0002);
    q_pulse(1'b0, 1);
    check({31'h0, lbStall}, 32'h0);
    q_pulse(1'b1, 5);
    rd_chk(ADDR_QOCC, 32'h0000_0004);
    lbOpRequest = 1'b0;
    // Translated address hold copies
    xlate(1'b0, 32'hAAAA_1000);
    xlate(1'b1, 32'hBBBB_2000);
    @(posedge clock);
    #1;
    check(data_phys_addr_copy, 32'hAAAA_1000);
    check(instr_phys_addr_copy, 32'hBBBB_2000);
    check(phys_addr_hold, 32'hBBBB_2000);
    // Table walks: full load walk, slow store walk, shortcut, fault
    walk_memory_model_inst.mem[32'h1008] = 32'h0000_2001;
    walk_memory_model_inst.mem[32'h200C] = 32'h0000_3001;
    walk_memory_model_inst.mem[32'h3008] = 32'h0000_4001;
    walk_memory_model_inst.mem[32'h4014] = 32'h0001_2302;
    tlb_replacement_counter = 5'h17;
    walk(32'h0308_5000, 1'b0, 1'b0);
    check(reads, 4);
    check({27'h0, slotSeen}, 32'h17);
    check(entrySeen, 32'h0001_2322);
    tlb_replacement_counter = 5'h03;
    ackDelay = 4'h5;
    walk(32'h0308_5000, 1'b1, 1'b0);
    check({27'h0, slotSeen}, 32'h03);
    check(walk_memory_model_inst.mem[32'h4014], 32'h0001_2362);
    ackDelay = 4'h0;
    tlb_replacement_control = 32'h0010_0000;
    l2PtpEntry = 32'h0000_4001;
    walk(32'h0308_5000, 1'b0, 1'b1);
    check(reads, 1);
    check(entrySeen, 32'h0001_2362);
    walkIsIo = 1'b1;
    walk(32'h0308_5000, 1'b0, 1'b0);
    walkIsIo = 1'b0;
    check(reads, 0);
    check({30'h0, doneSeen, faultSeen}, 32'h0);
    walk(32'h0308_6000, 1'b0, 1'b1);
    check({30'h0, doneSeen, faultSeen}, 32'h1);
    print_verdict();
  end
endmodule
